// ---- verilog/itcx_pkg.sv ----
package itcx_pkg;

  // Instruction codes, ten bits wide
  localparam int unsigned        OP_W                   = 10;
  localparam logic [OP_W-1:0]    OP_IRQ_OFF             = 10'h004;
  localparam logic [OP_W-1:0]    OP_IRQ_ON              = 10'h005;
  localparam logic [OP_W-1:0]    OP_SKIP_EXT0_FLAG      = 10'h038;
  localparam logic [OP_W-1:0]    OP_SKIP_EXT1_FLAG      = 10'h039;
  localparam logic [OP_W-1:0]    OP_SKIP_PIN0_LEVEL     = 10'h03A;
  localparam logic [OP_W-1:0]    OP_SKIP_PIN1_LEVEL     = 10'h03B;
  localparam logic [OP_W-1:0]    OP_COPY_IRQ_ONE_TO_ACC = 10'h054;
  localparam logic [OP_W-1:0]    OP_LOAD_IRQ_ONE        = 10'h03F;
  localparam logic [OP_W-1:0]    OP_COPY_IRQ_TWO_TO_ACC = 10'h055;
  localparam logic [OP_W-1:0]    OP_LOAD_IRQ_TWO        = 10'h03E;
  localparam logic [OP_W-1:0]    OP_COPY_CFG0_TO_ACC    = 10'h253;
  localparam logic [OP_W-1:0]    OP_LOAD_CFG0           = 10'h217;
  localparam logic [OP_W-1:0]    OP_COPY_CFG1_TO_ACC    = 10'h254;
  localparam logic [OP_W-1:0]    OP_LOAD_CFG1           = 10'h218;
  localparam logic [OP_W-1:0]    OP_LOAD_TIMER_PIN      = 10'h2AA;
  localparam logic [OP_W-1:0]    OP_COPY_TMR1_TO_ACC    = 10'h24B;
  localparam logic [OP_W-1:0]    OP_LOAD_TMR1           = 10'h20E;
  localparam logic [OP_W-1:0]    OP_COPY_TMR2_TO_ACC    = 10'h24C;
  localparam logic [OP_W-1:0]    OP_LOAD_TMR2           = 10'h20F;
  localparam logic [OP_W-1:0]    OP_COPY_TMR3_TO_ACC    = 10'h24D;
  localparam logic [OP_W-1:0]    OP_LOAD_TMR3           = 10'h210;
  localparam logic [OP_W-1:0]    OP_COPY_TMR4_TO_ACC    = 10'h24E;
  localparam logic [OP_W-1:0]    OP_LOAD_TMR4           = 10'h211;

  // Control register file indices
  localparam int unsigned        SEL_W                  = 4;
  localparam logic [SEL_W-1:0]   SEL_IRQ_ONE            = 4'h0;
  localparam logic [SEL_W-1:0]   SEL_IRQ_TWO            = 4'h1;
  localparam logic [SEL_W-1:0]   SEL_CFG0               = 4'h2;
  localparam logic [SEL_W-1:0]   SEL_CFG1               = 4'h3;
  localparam logic [SEL_W-1:0]   SEL_TIMER_PIN          = 4'h4;
  localparam logic [SEL_W-1:0]   SEL_TMR1               = 4'h5;
  localparam logic [SEL_W-1:0]   SEL_TMR2               = 4'h6;
  localparam logic [SEL_W-1:0]   SEL_TMR3               = 4'h7;
  localparam logic [SEL_W-1:0]   SEL_TMR4               = 4'h8;
  localparam logic [SEL_W-1:0]   SEL_NONE               = 4'hF;
  localparam int unsigned        NUM_CTRL               = 9;

  // Field positions and reset values
  localparam int unsigned        NIB_W                  = 4;
  localparam int unsigned        EXT0_SKIP_DIS_BIT      = 0;
  localparam int unsigned        EXT1_SKIP_DIS_BIT      = 1;
  localparam int unsigned        LEVEL_SEL_BIT          = 2;
  localparam logic [NIB_W-1:0]   TIMER_PIN_MASK         = 4'h1;
  localparam logic [NIB_W-1:0]   CTRL_RST               = 4'h0;

  // Wishbone register map, byte addresses
  localparam int unsigned        ADR_W                  = 8;
  localparam logic [ADR_W-1:0]   ADR_STATE              = 8'h00;
  localparam logic [ADR_W-1:0]   ADR_IRQ_STAT           = 8'h04;
  localparam logic [ADR_W-1:0]   ADR_IRQ_MASK           = 8'h08;
  localparam logic [ADR_W-1:0]   ADR_IRQ_REGS           = 8'h0C;
  localparam logic [ADR_W-1:0]   ADR_TMR_REGS           = 8'h10;

  // State register fields
  localparam int unsigned        ST_GIE                 = 0;
  localparam int unsigned        ST_EXT0_FLAG           = 1;
  localparam int unsigned        ST_EXT1_FLAG           = 2;
  localparam int unsigned        ST_SKIP_PEND           = 3;
  localparam int unsigned        ST_PIN0                = 4;
  localparam int unsigned        ST_PIN1                = 5;

  // Interrupt status fields
  localparam int unsigned        EVT_W                  = 3;
  localparam int unsigned        EV_EXT0_SET            = 0;
  localparam int unsigned        EV_EXT1_SET            = 1;
  localparam int unsigned        EV_SKIP_TAKEN          = 2;
  localparam logic [EVT_W-1:0]   EVT_RST                = 3'h0;

  typedef enum logic {
    EXEC_RUN,
    EXEC_SKIP
  } itcx_state_t;

endpackage

// ---- verilog/itcx_pin_sync.sv ----
`timescale 1ns/10ps
module itcx_pin_sync
  import itcx_pkg::*;
#(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Three stages; only the second and third are compared
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A level counts once two stages agree, which rejects one-cycle glitches
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      level_o <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ---- verilog/itcx_exec.sv ----
// Function
// - interrupt-off op clears global enable
// - interrupt-on op sets global enable
// - ext0 flag set: skip, then clear
// - ext0 skip-disable set: test is no-op
// - ext1 flag set: skip, then clear
// - ext1 skip-disable set: test is no-op
// - skip when pin0 level matches select
// - skip when pin1 level matches select
// - copy interrupt registers into accumulator
// - load interrupt registers from accumulator
// - load timer pin control from accumulator
// - copy timer controls into accumulator
// - load timer controls from accumulator
// - ext0 flag clear: no skip, unchanged
`timescale 1ns/10ps
module itcx_exec
  import itcx_pkg::*;
(
  // Clock, reset, enable
  input  wire logic             CLK_SYS_I,
  input  wire logic             RST_N_I,
  input  wire logic             CE_I,
  // Instruction issue from sequencer
  input  wire logic             EXEC_STB_I,
  input  wire logic [OP_W-1:0]  OPCODE_I,
  input  wire logic [NIB_W-1:0] ACC_I,
  // Accumulator write back
  output logic                  ACC_WE_O,
  output logic      [NIB_W-1:0] ACC_O,
  // Skip decision to sequencer
  output logic                  SKIP_O,
  // External request events and pins
  input  wire logic             EXT0_EVT_I,
  input  wire logic             EXT1_EVT_I,
  input  wire logic             EXT_IRQ_PIN0_I,
  input  wire logic             EXT_IRQ_PIN1_I,
  // Core state out
  output logic                  GLOBAL_IRQ_ENABLE_O,
  output logic                  EXT0_REQUEST_FLAG_O,
  output logic                  EXT1_REQUEST_FLAG_O,
  output logic      [NIB_W-1:0] IRQ_CTRL_ONE_O,
  output logic      [NIB_W-1:0] IRQ_CTRL_TWO_O,
  output logic      [NIB_W-1:0] EXT_IRQ_CFG_ZERO_O,
  output logic      [NIB_W-1:0] EXT_IRQ_CFG_ONE_O,
  output logic                  TIMER_PIN_CTRL_O,
  output logic      [NIB_W-1:0] TMR_CTRL_ONE_O,
  output logic      [NIB_W-1:0] TMR_CTRL_TWO_O,
  output logic      [NIB_W-1:0] TMR_CTRL_THREE_O,
  output logic      [NIB_W-1:0] TMR_CTRL_FOUR_O,
  // Wishbone slave
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic      [31:0]      WB_DAT_O,
  output logic                  WB_ACK_O,
  // Interrupt
  output logic                  IRQ_O
);

  // Register index read by a copy-to-accumulator opcode
  function automatic logic [SEL_W-1:0] read_sel(input logic [OP_W-1:0] op);
    logic [SEL_W-1:0] s;
    s = SEL_NONE;
    if (op == OP_COPY_IRQ_ONE_TO_ACC) begin
      s = SEL_IRQ_ONE;
    end else if (op == OP_COPY_IRQ_TWO_TO_ACC) begin
      s = SEL_IRQ_TWO;
    end else if (op == OP_COPY_CFG0_TO_ACC) begin
      s = SEL_CFG0;
    end else if (op == OP_COPY_CFG1_TO_ACC) begin
      s = SEL_CFG1;
    end else if (op == OP_COPY_TMR1_TO_ACC) begin
      s = SEL_TMR1;
    end else if (op == OP_COPY_TMR2_TO_ACC) begin
      s = SEL_TMR2;
    end else if (op == OP_COPY_TMR3_TO_ACC) begin
      s = SEL_TMR3;
    end else if (op == OP_COPY_TMR4_TO_ACC) begin
      s = SEL_TMR4;
    end
    return s;
  endfunction

  // Register index written by a load-from-accumulator opcode
  function automatic logic [SEL_W-1:0] write_sel(input logic [OP_W-1:0] op);
    logic [SEL_W-1:0] s;
    s = SEL_NONE;
    if (op == OP_LOAD_IRQ_ONE) begin
      s = SEL_IRQ_ONE;
    end else if (op == OP_LOAD_IRQ_TWO) begin
      s = SEL_IRQ_TWO;
    end else if (op == OP_LOAD_CFG0) begin
      s = SEL_CFG0;
    end else if (op == OP_LOAD_CFG1) begin
      s = SEL_CFG1;
    end else if (op == OP_LOAD_TIMER_PIN) begin
      s = SEL_TIMER_PIN;
    end else if (op == OP_LOAD_TMR1) begin
      s = SEL_TMR1;
    end else if (op == OP_LOAD_TMR2) begin
      s = SEL_TMR2;
    end else if (op == OP_LOAD_TMR3) begin
      s = SEL_TMR3;
    end else if (op == OP_LOAD_TMR4) begin
      s = SEL_TMR4;
    end
    return s;
  endfunction

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  itcx_state_t      state_q;
  itcx_state_t      state_d;
  logic [NIB_W-1:0] ctrl_q [NUM_CTRL];
  logic             gie_q;
  logic             ext0_flag_q;
  logic             ext1_flag_q;
  logic [1:0]       pin_level;
  logic             run_op;
  logic             skip_now;
  logic             ext0_test_clr;
  logic             ext1_test_clr;
  logic [SEL_W-1:0] rd_idx;
  logic [SEL_W-1:0] wr_idx;
  logic [EVT_W-1:0] irq_stat_q;
  logic [EVT_W-1:0] irq_mask_q;
  logic [EVT_W-1:0] evt;
  logic             wb_req;
  logic             wb_wr;
  logic [31:0]      stat_merge;
  logic [31:0]      mask_merge;

  // Pins come from outside the clock domain
  itcx_pin_sync #(
    .W       (2)
  ) u_pin_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .pin_i   ({EXT_IRQ_PIN1_I, EXT_IRQ_PIN0_I}),
    .level_o (pin_level)
  );

  // Instruction decode; an op issued while skipping is swallowed
  assign run_op = CE_I && EXEC_STB_I && (state_q == EXEC_RUN);
  assign rd_idx = read_sel(OPCODE_I);
  assign wr_idx = write_sel(OPCODE_I);

  // Flag tests clear the flag only when they actually skip
  assign ext0_test_clr = run_op && (OPCODE_I == OP_SKIP_EXT0_FLAG)
                         && !ctrl_q[SEL_IRQ_ONE][EXT0_SKIP_DIS_BIT]
                         && ext0_flag_q;
  assign ext1_test_clr = run_op && (OPCODE_I == OP_SKIP_EXT1_FLAG)
                         && !ctrl_q[SEL_IRQ_ONE][EXT1_SKIP_DIS_BIT]
                         && ext1_flag_q;

  // Skip decision for the next instruction
  always_comb begin
    skip_now = 1'b0;
    if (run_op) begin
      if (OPCODE_I == OP_SKIP_EXT0_FLAG) begin
        skip_now = ext0_test_clr;
      end else if (OPCODE_I == OP_SKIP_EXT1_FLAG) begin
        skip_now = ext1_test_clr;
      end else if (OPCODE_I == OP_SKIP_PIN0_LEVEL) begin
        skip_now = (pin_level[0] == ctrl_q[SEL_CFG0][LEVEL_SEL_BIT]);
      end else if (OPCODE_I == OP_SKIP_PIN1_LEVEL) begin
        skip_now = (pin_level[1] == ctrl_q[SEL_CFG1][LEVEL_SEL_BIT]);
      end
    end
  end

  // Skip sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      EXEC_RUN: begin
        if (skip_now) begin
          state_d = EXEC_SKIP;
        end
      end
      EXEC_SKIP: begin
        if (CE_I && EXEC_STB_I) begin
          state_d = EXEC_RUN;
        end
      end
      default: begin
        state_d = EXEC_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_q <= EXEC_RUN;
    end else if (CE_I) begin
      state_q <= state_d;
    end
  end

  // Global interrupt enable
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      gie_q <= 1'b0;
    end else if (run_op) begin
      if (OPCODE_I == OP_IRQ_OFF) begin
        gie_q <= 1'b0;
      end else if (OPCODE_I == OP_IRQ_ON) begin
        gie_q <= 1'b1;
      end
    end
  end

  // Request flags; a new request wins over a same-cycle clear
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ext0_flag_q <= 1'b0;
      ext1_flag_q <= 1'b0;
    end else if (CE_I) begin
      if (EXT0_EVT_I) begin
        ext0_flag_q <= 1'b1;
      end else if (ext0_test_clr) begin
        ext0_flag_q <= 1'b0;
      end
      if (EXT1_EVT_I) begin
        ext1_flag_q <= 1'b1;
      end else if (ext1_test_clr) begin
        ext1_flag_q <= 1'b0;
      end
    end
  end

  // Control register file loaded from the accumulator
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < NUM_CTRL; i++) begin
        ctrl_q[i] <= CTRL_RST;
      end
    end else if (run_op && (wr_idx != SEL_NONE)) begin
      if (wr_idx == SEL_TIMER_PIN) begin
        ctrl_q[wr_idx] <= ACC_I & TIMER_PIN_MASK;
      end else begin
        ctrl_q[wr_idx] <= ACC_I;
      end
    end
  end

  // Accumulator write back, one cycle after issue; carry never touched
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      ACC_WE_O <= 1'b0;
      ACC_O    <= CTRL_RST;
    end else if (CE_I) begin
      ACC_WE_O <= run_op && (rd_idx != SEL_NONE);
      if (run_op && (rd_idx != SEL_NONE)) begin
        ACC_O <= ctrl_q[rd_idx];
      end
    end
  end

  // State to the rest of the core
  assign SKIP_O              = (state_q == EXEC_SKIP);
  assign GLOBAL_IRQ_ENABLE_O = gie_q;
  assign EXT0_REQUEST_FLAG_O = ext0_flag_q;
  assign EXT1_REQUEST_FLAG_O = ext1_flag_q;
  assign IRQ_CTRL_ONE_O      = ctrl_q[SEL_IRQ_ONE];
  assign IRQ_CTRL_TWO_O      = ctrl_q[SEL_IRQ_TWO];
  assign EXT_IRQ_CFG_ZERO_O  = ctrl_q[SEL_CFG0];
  assign EXT_IRQ_CFG_ONE_O   = ctrl_q[SEL_CFG1];
  assign TIMER_PIN_CTRL_O    = ctrl_q[SEL_TIMER_PIN][0];
  assign TMR_CTRL_ONE_O      = ctrl_q[SEL_TMR1];
  assign TMR_CTRL_TWO_O      = ctrl_q[SEL_TMR2];
  assign TMR_CTRL_THREE_O    = ctrl_q[SEL_TMR3];
  assign TMR_CTRL_FOUR_O     = ctrl_q[SEL_TMR4];

  // Events for software: flag rising and skip taken
  always_comb begin
    evt                = '0;
    evt[EV_EXT0_SET]   = CE_I && EXT0_EVT_I && !ext0_flag_q;
    evt[EV_EXT1_SET]   = CE_I && EXT1_EVT_I && !ext1_flag_q;
    evt[EV_SKIP_TAKEN] = skip_now;
  end

  // Single-cycle Wishbone answer; ack drops the cycle after it was given
  assign wb_req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr      = wb_req && WB_WE_I;
  assign stat_merge = lane_merge(32'h0000_0000, WB_DAT_I, WB_SEL_I);
  assign mask_merge = lane_merge({29'h0000_0000, irq_mask_q}, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      WB_ACK_O <= 1'b0;
    end else if (CE_I) begin
      WB_ACK_O <= wb_req;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_stat_q <= EVT_RST;
    end else if (CE_I) begin
      if (wb_wr && (WB_ADR_I == ADR_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~stat_merge[EVT_W-1:0]) | evt;
      end else begin
        irq_stat_q <= irq_stat_q | evt;
      end
    end
  end

  // Mask register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_mask_q <= EVT_RST;
    end else if (CE_I && wb_wr && (WB_ADR_I == ADR_IRQ_MASK)) begin
      irq_mask_q <= mask_merge[EVT_W-1:0];
    end
  end

  // Read data; unmapped addresses read zero and writes there are dropped
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE_I && wb_req && !WB_WE_I) begin
      WB_DAT_O <= 32'h0000_0000;
      if (WB_ADR_I == ADR_STATE) begin
        WB_DAT_O[ST_GIE]       <= gie_q;
        WB_DAT_O[ST_EXT0_FLAG] <= ext0_flag_q;
        WB_DAT_O[ST_EXT1_FLAG] <= ext1_flag_q;
        WB_DAT_O[ST_SKIP_PEND] <= (state_q == EXEC_SKIP);
        WB_DAT_O[ST_PIN0]      <= pin_level[0];
        WB_DAT_O[ST_PIN1]      <= pin_level[1];
      end else if (WB_ADR_I == ADR_IRQ_STAT) begin
        WB_DAT_O[EVT_W-1:0] <= irq_stat_q;
      end else if (WB_ADR_I == ADR_IRQ_MASK) begin
        WB_DAT_O[EVT_W-1:0] <= irq_mask_q;
      end else if (WB_ADR_I == ADR_IRQ_REGS) begin
        WB_DAT_O[15:0] <= {ctrl_q[SEL_CFG1], ctrl_q[SEL_CFG0],
                           ctrl_q[SEL_IRQ_TWO], ctrl_q[SEL_IRQ_ONE]};
      end else if (WB_ADR_I == ADR_TMR_REGS) begin
        WB_DAT_O[19:0] <= {ctrl_q[SEL_TMR4], ctrl_q[SEL_TMR3], ctrl_q[SEL_TMR2],
                           ctrl_q[SEL_TMR1], ctrl_q[SEL_TIMER_PIN]};
      end
    end
  end

  // Level interrupt from unmasked sticky bits
  assign IRQ_O = |(irq_stat_q & irq_mask_q);

endmodule

// ---- verification/itcx_seq_model.sv ----
`timescale 1ns/10ps
module itcx_seq_model
  import itcx_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Immediate load ordered by the bench
  input  wire logic             preset_i,
  input  wire logic [NIB_W-1:0] preset_val_i,
  // Write back from the block
  input  wire logic             acc_we_i,
  input  wire logic [NIB_W-1:0] acc_i,
  // Accumulator seen by the block
  output logic      [NIB_W-1:0] acc_o
);
  // Accumulator; write back wins, as it belongs to the older instruction
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_o <= 4'h0;
    end else if (acc_we_i) begin
      acc_o <= acc_i;
    end else if (preset_i) begin
      acc_o <= preset_val_i;
    end
  end
endmodule

// ---- verification/itcx_exec_monitor.sv ----
`timescale 1ns/10ps
module itcx_exec_monitor
  import itcx_pkg::*;
(
  // Clock, reset, enable
  input wire logic             CLK_SYS_I,
  input wire logic             RST_N_I,
  input wire logic             CE_I,
  // Instruction port
  input wire logic             EXEC_STB_I,
  input wire logic [OP_W-1:0]  OPCODE_I,
  input wire logic [NIB_W-1:0] ACC_I,
  input wire logic             ACC_WE_O,
  input wire logic [NIB_W-1:0] ACC_O,
  input wire logic             SKIP_O,
  // Flags and registers
  input wire logic             EXT0_EVT_I,
  input wire logic             EXT1_EVT_I,
  input wire logic             GLOBAL_IRQ_ENABLE_O,
  input wire logic             EXT0_REQUEST_FLAG_O,
  input wire logic             EXT1_REQUEST_FLAG_O,
  input wire logic [NIB_W-1:0] IRQ_CTRL_ONE_O,
  input wire logic [NIB_W-1:0] TMR_CTRL_ONE_O,
  // Wishbone handshake
  input wire logic             WB_CYC_I,
  input wire logic             WB_STB_I,
  input wire logic             WB_ACK_O
);
  // Instruction that executes, not one being swallowed
  logic go;
  assign go = CE_I && EXEC_STB_I && !SKIP_O;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);

  gie_clear_a:
    assert property (go && OPCODE_I == OP_IRQ_OFF |=> !GLOBAL_IRQ_ENABLE_O)
    else $error("enable not cleared");
  gie_set_a:
    assert property (go && OPCODE_I == OP_IRQ_ON |=> GLOBAL_IRQ_ENABLE_O)
    else $error("enable not set");
  ext0_skip_a:
    assert property (go && OPCODE_I == OP_SKIP_EXT0_FLAG && !IRQ_CTRL_ONE_O[0]
      && EXT0_REQUEST_FLAG_O && !EXT0_EVT_I |=> SKIP_O && !EXT0_REQUEST_FLAG_O)
    else $error("ext0 test did not skip and clear");
  ext0_nop_a:
    assert property (go && OPCODE_I == OP_SKIP_EXT0_FLAG && IRQ_CTRL_ONE_O[0]
      && !EXT0_EVT_I |=> !SKIP_O && $stable(EXT0_REQUEST_FLAG_O))
    else $error("ext0 test not a no-op");
  ext0_idle_a:
    assert property (go && OPCODE_I == OP_SKIP_EXT0_FLAG && !EXT0_REQUEST_FLAG_O
      && !EXT0_EVT_I |=> !SKIP_O && !EXT0_REQUEST_FLAG_O)
    else $error("ext0 test skipped on clear flag");
  ext1_skip_a:
    assert property (go && OPCODE_I == OP_SKIP_EXT1_FLAG && !IRQ_CTRL_ONE_O[1]
      && EXT1_REQUEST_FLAG_O && !EXT1_EVT_I |=> SKIP_O && !EXT1_REQUEST_FLAG_O)
    else $error("ext1 test did not skip and clear");
  ext1_nop_a:
    assert property (go && OPCODE_I == OP_SKIP_EXT1_FLAG && IRQ_CTRL_ONE_O[1]
      && !EXT1_EVT_I |=> !SKIP_O && $stable(EXT1_REQUEST_FLAG_O))
    else $error("ext1 test not a no-op");
  acc_copy_a:
    assert property (go && OPCODE_I == OP_COPY_IRQ_ONE_TO_ACC
      |=> ACC_WE_O && ACC_O == $past(IRQ_CTRL_ONE_O))
    else $error("copy to accumulator wrong");
  tmr_load_a:
    assert property (go && OPCODE_I == OP_LOAD_TMR1 |=> TMR_CTRL_ONE_O == $past(ACC_I))
    else $error("timer control load wrong");
  skip_swallow_a:
    assert property (CE_I && EXEC_STB_I && SKIP_O |=> !SKIP_O && !ACC_WE_O
      && $stable(GLOBAL_IRQ_ENABLE_O) && $stable(TMR_CTRL_ONE_O))
    else $error("skipped instruction had an effect");
  wb_ack_a:
    assert property (CE_I && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus ack late");
  wb_pulse_a:
    assert property (CE_I && WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack longer than one cycle");

  // Main scenarios reached
  cover property (go && OPCODE_I == OP_SKIP_EXT0_FLAG ##1 SKIP_O);
  cover property (CE_I && EXEC_STB_I && SKIP_O);
  cover property (ACC_WE_O);
endmodule

bind itcx_exec itcx_exec_monitor itcx_exec_monitor_i (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .EXEC_STB_I(EXEC_STB_I),
  .OPCODE_I(OPCODE_I), .ACC_I(ACC_I), .ACC_WE_O(ACC_WE_O), .ACC_O(ACC_O),
  .SKIP_O(SKIP_O), .EXT0_EVT_I(EXT0_EVT_I), .EXT1_EVT_I(EXT1_EVT_I),
  .GLOBAL_IRQ_ENABLE_O(GLOBAL_IRQ_ENABLE_O), .EXT0_REQUEST_FLAG_O(EXT0_REQUEST_FLAG_O),
  .EXT1_REQUEST_FLAG_O(EXT1_REQUEST_FLAG_O), .IRQ_CTRL_ONE_O(IRQ_CTRL_ONE_O),
  .TMR_CTRL_ONE_O(TMR_CTRL_ONE_O), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O)
);

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import itcx_pkg::*;

  logic             clk_sys, rst_n, stb, ev0, ev1, pin0, pin1, preset;
  logic             acc_we, skip, gie, f0, f1, r_pa, cyc, wstb, we, ack, irq;
  logic [OP_W-1:0]  op;
  logic [NIB_W-1:0] acc, acc_val, pval, r_v1, r_v2, r_i1, r_i2, r_w1, r_w2, r_w3, r_w4;
  logic [ADR_W-1:0] adr;
  logic [3:0]       sel;
  logic [31:0]      wdat, rdat, rd;
  logic [15:0]      lf;
  int               error_cnt, tests_run, k, n, d, s, l;
  logic [OP_W-1:0]  ld_op [9] = '{OP_LOAD_IRQ_ONE, OP_LOAD_IRQ_TWO, OP_LOAD_CFG0,
    OP_LOAD_CFG1, OP_LOAD_TIMER_PIN, OP_LOAD_TMR1, OP_LOAD_TMR2, OP_LOAD_TMR3, OP_LOAD_TMR4};
  logic [OP_W-1:0]  cp_op [9] = '{OP_COPY_IRQ_ONE_TO_ACC, OP_COPY_IRQ_TWO_TO_ACC,
    OP_COPY_CFG0_TO_ACC, OP_COPY_CFG1_TO_ACC, 10'h000, OP_COPY_TMR1_TO_ACC,
    OP_COPY_TMR2_TO_ACC, OP_COPY_TMR3_TO_ACC, OP_COPY_TMR4_TO_ACC};

  itcx_exec itcx_exec_i (
    .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .CE_I(1'b1), .EXEC_STB_I(stb), .OPCODE_I(op),
    .ACC_I(acc), .ACC_WE_O(acc_we), .ACC_O(acc_val), .SKIP_O(skip), .EXT0_EVT_I(ev0),
    .EXT1_EVT_I(ev1), .EXT_IRQ_PIN0_I(pin0), .EXT_IRQ_PIN1_I(pin1),
    .GLOBAL_IRQ_ENABLE_O(gie), .EXT0_REQUEST_FLAG_O(f0), .EXT1_REQUEST_FLAG_O(f1),
    .IRQ_CTRL_ONE_O(r_v1), .IRQ_CTRL_TWO_O(r_v2), .EXT_IRQ_CFG_ZERO_O(r_i1),
    .EXT_IRQ_CFG_ONE_O(r_i2), .TIMER_PIN_CTRL_O(r_pa), .TMR_CTRL_ONE_O(r_w1),
    .TMR_CTRL_TWO_O(r_w2), .TMR_CTRL_THREE_O(r_w3), .TMR_CTRL_FOUR_O(r_w4),
    .WB_CYC_I(cyc), .WB_STB_I(wstb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_O(irq));

  itcx_seq_model itcx_seq_model_i (.clk_i(clk_sys), .rst_n_i(rst_n), .preset_i(preset),
    .preset_val_i(pval), .acc_we_i(acc_we), .acc_i(acc_val), .acc_o(acc));

  // Clock, 100 ns period
  always #50 clk_sys = ~clk_sys;

  // Fixed-seed pseudo random source
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Expected skip of a pin level test
  function automatic logic pin_skip(input logic lvl, input logic lsel);
    return lvl == lsel;
  endfunction

  // Register output picked by control index
  function automatic logic [NIB_W-1:0] reg_of(input int i);
    case (i)
      0: return r_v1;
      1: return r_v2;
      2: return r_i1;
      3: return r_i2;
      4: return {3'h0, r_pa};
      5: return r_w1;
      6: return r_w2;
      7: return r_w3;
      default: return r_w4;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] dt);
    @(posedge clk_sys);
    cyc <= 1'b1;
    wstb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= dt;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    wstb <= 1'b0;
  endtask

  task automatic set_acc(input logic [NIB_W-1:0] v);
    @(posedge clk_sys);
    preset <= 1'b1;
    pval <= v;
    @(posedge clk_sys);
    preset <= 1'b0;
  endtask

  task automatic issue(input logic [OP_W-1:0] o);
    @(posedge clk_sys);
    stb <= 1'b1;
    op <= o;
    @(posedge clk_sys);
    stb <= 1'b0;
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev0 <= (i == 0);
    ev1 <= (i == 1);
    @(posedge clk_sys);
    ev0 <= 1'b0;
    ev1 <= 1'b0;
    #1;
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  initial begin
    {clk_sys, rst_n, stb, ev0, ev1, pin0, pin1, preset, cyc, wstb, we} = '0;
    {op, pval, adr, sel, wdat} = '0;
    error_cnt = 0;
    tests_run = 0;
    lf = 16'h4A1D;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Unmapped write, then reset values and an unmapped read
    wb(1'b1, 8'h40, 32'hFFFFFFFF);
    for (k = 0; k < 6; k++) begin
      wb(1'b0, (k == 5) ? 8'h40 : 8'(k * 4), 32'h0);
      check(rd, 32'h0);
    end
    // Every load and copy with random nibbles
    for (k = 0; k < 9; k++) begin
      lf = lfsr(lf);
      set_acc(lf[3:0]);
      issue(ld_op[k]);
      check(32'(reg_of(k)), 32'((k == 4) ? (lf[3:0] & TIMER_PIN_MASK) : lf[3:0]));
      if (k != 4) begin
        set_acc(~lf[3:0]);
        issue(cp_op[k]);
        @(posedge clk_sys);
        #1;
        check(32'(acc), 32'(lf[3:0]));
      end
    end
    // Flag tests with skip-disable off then on; follower swallowed or not
    for (n = 0; n < 2; n++) begin
      for (d = 0; d < 2; d++) begin
        set_acc(4'(d << n));
        issue(OP_LOAD_IRQ_ONE);
        issue(n ? OP_SKIP_EXT1_FLAG : OP_SKIP_EXT0_FLAG);
        check(32'(skip), 32'h0);
        pulse(n);
        issue(n ? OP_SKIP_EXT1_FLAG : OP_SKIP_EXT0_FLAG);
        check(32'({skip, n ? f1 : f0}), 32'(d ? 2'h1 : 2'h2));
        issue(OP_IRQ_ON);
        check(32'({skip, gie}), 32'(d));
        issue(OP_IRQ_OFF);
        check(32'(gie), 32'h0);
      end
    end
    // Flags both set, enable off
    wb(1'b0, ADR_STATE, 32'h0);
    check(rd, 32'h6);
    // Status holds both rises and the skip; mask, clear
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check(rd, 32'h7);
    check(32'(irq), 32'h0);
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    #1;
    check(32'(irq), 32'h1);
    wb(1'b1, ADR_IRQ_STAT, 32'h1);
    #1;
    check(32'(irq), 32'h0);
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check(rd, 32'h6);
    // Pin level tests over pin, select and level
    for (n = 0; n < 2; n++) begin
      for (s = 0; s < 2; s++) begin
        for (l = 0; l < 2; l++) begin
          lf = lfsr(lf);
          set_acc((lf[3:0] & 4'hB) | 4'(s << 2));
          pin0 <= l[0];
          pin1 <= l[0];
          issue(n ? OP_LOAD_CFG1 : OP_LOAD_CFG0);
          repeat (8) @(posedge clk_sys);
          issue(n ? OP_SKIP_PIN1_LEVEL : OP_SKIP_PIN0_LEVEL);
          check(32'(skip), 32'(pin_skip(l[0], s[0])));
          issue(10'h000);
        end
      end
    end
    stop_test();
  end
endmodule
